// ===== core/hap_pkg.sv
package hap_pkg;
   // Host pin bundle positions
   localparam int PIN_W = 5;
   localparam int PIN_CS = 0;
   localparam int PIN_HBR = 1;
   localparam int PIN_RD = 2;
   localparam int PIN_WR = 3;
   localparam int PIN_SUSPEND_BUS_TRISTATE_N = 4;
   // All host pins idle high
   localparam logic [PIN_W-1:0] PIN_IDLE = 5'h1f;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_WAIT_BUS = 3'b001,
      ST_TRISTATE = 3'b010,
      ST_GRANT = 3'b011,
      ST_ACCESS = 3'b100,
      ST_HOLD = 3'b101,
      ST_RELEASE = 3'b110
   } hap_state_type;
endpackage : hap_pkg

// ===== core/hap_pin_if.sv
`timescale 1ns/1ps
interface hap_pin_if;
   import hap_pkg::*;
   logic [PIN_W-1:0] pins;
   modport src (output pins);
   modport dst (input pins);
endinterface : hap_pin_if

// ===== core/hap_pin_sync.sv
`timescale 1ns/1ps
module hap_pin_sync
   import hap_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Raw pins
   input wire logic [PIN_W-1:0] raw_i,
   // Filtered pins
   hap_pin_if.src sync
);
   logic [PIN_W-1:0] s1_ff;
   logic [PIN_W-1:0] s2_ff;
   logic [PIN_W-1:0] s3_ff;
   logic [PIN_W-1:0] out_ff;

   genvar g;
   generate
      for (g = 0; g < PIN_W; g++)
      begin : g_bit
         always_ff @(posedge ref_clk_i or negedge rst_n_i)
         begin
            if (!rst_n_i)
            begin
               s1_ff[g] <= PIN_IDLE[g];
               s2_ff[g] <= PIN_IDLE[g];
               s3_ff[g] <= PIN_IDLE[g];
               out_ff[g] <= PIN_IDLE[g];
            end
            else
            begin
               s1_ff[g] <= raw_i[g];
               s2_ff[g] <= s1_ff[g];
               s3_ff[g] <= s2_ff[g];
               // Change counts only once two late stages agree
               if (s2_ff[g] == s3_ff[g])
                  out_ff[g] <= s3_ff[g];
            end
         end
      end
   endgenerate

   assign sync.pins = out_ff;
endmodule : hap_pin_sync

// ===== core/hap_host_port.sv
`timescale 1ns/1ps
// What this block and its host do
// R1 - Host holds select and request low throughout
// R2 - Strobes accepted only after grant returned
// R3 - Accesses defined only while request, grant low
// R4 - First address outside multiprocessor space, host duty
// R5 - Host drives upper address high on grant
// R6 - Ready low on strobe, released when done
// R7 - Host holds strobe until ready released
// R8 - Ready selectable open-drain or active drive
// R9 - Ready release aligned to input clock
// R10 - Tristate before grant, re-enable after release
// R11 - Tristate on transitions and suspend input
// R12 - Tristate group covers address, strobes, selects
// R13 - Outputs disabled/enabled on clock edges
// R14 - Data enable clock aligned during transitions
// R15 - Suspend input sampled, stops then resumes driving
// R16 - Ready low while select and request low; block holds it low until the first access is done, then only during accesses
// R17 - Grant after bus cycle, held until release
module hap_host_port
   import hap_pkg::*;
(
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Host pins
   input wire logic host_cs_n_i,
   input wire logic host_bus_request_n_i,
   input wire logic host_rd_n_i,
   input wire logic host_wr_n_i,
   input wire logic suspend_bus_tristate_n_i,
   output logic host_bus_grant_n_o,
   output logic host_bus_grant_oe_o,
   output logic host_access_ready_o,
   output logic host_access_ready_oe_o,
   output logic host_data_oe_o,
   // Configuration
   input wire logic ready_open_drain_i,
   // Memory interface drive control
   output logic mem_if_oe_o,
   output logic address_clock_out_oe_o,
   // Core side
   input wire logic core_bus_busy_i,
   input wire logic acc_done_i,
   output logic acc_req_o,
   output logic acc_write_o
);
   hap_pin_if pin_bus ();

   hap_pin_sync u_sync (
      .ref_clk_i (ref_clk_i),
      .rst_n_i (rst_n_i),
      .raw_i ({suspend_bus_tristate_n_i, host_wr_n_i, host_rd_n_i, host_bus_request_n_i, host_cs_n_i}),
      .sync (pin_bus.src)
   );

   ////////////////////////////////////////////////////////////////////////
   logic cs_n;
   logic hbr_n;
   logic rd_n;
   logic wr_n;
   logic suspend_bus_tristate_n_n;
   logic host_req;
   logic strobe_lo;

   assign cs_n = pin_bus.pins[PIN_CS];
   assign hbr_n = pin_bus.pins[PIN_HBR];
   assign rd_n = pin_bus.pins[PIN_RD];
   assign wr_n = pin_bus.pins[PIN_WR];
   assign suspend_bus_tristate_n_n = pin_bus.pins[PIN_SUSPEND_BUS_TRISTATE_N];
   assign host_req = !cs_n && !hbr_n; // [R1]
   assign strobe_lo = !rd_n || (!wr_n && !cs_n); // [R6]

   hap_state_type state_ff;
   hap_state_type nxt_state;
   logic grant_n_ff;
   logic ready_ff;
   logic ready_oe_ff;
   logic data_oe_ff;
   logic mem_oe_ff;
   logic grant_oe_ff;
   logic nxt_ready;
   logic acc_req_ff;
   logic acc_write_ff;

   ////////////////////////////////////////////////////////////////////////
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         ST_IDLE:
            if (!hbr_n)
               nxt_state = ST_WAIT_BUS;
         ST_WAIT_BUS:
            if (hbr_n)
               nxt_state = ST_IDLE;
            else if (!core_bus_busy_i)
               nxt_state = ST_TRISTATE; // [R17]
         ST_TRISTATE:
            nxt_state = ST_GRANT; // [R10]
         ST_GRANT:
            if (hbr_n)
               nxt_state = ST_RELEASE; // [R17]
            else if (strobe_lo)
               nxt_state = ST_ACCESS; // [R2] [R3]
         ST_ACCESS:
            if (acc_done_i)
               nxt_state = ST_HOLD;
         ST_HOLD:
            // Host raises the strobe only after ready returns
            if (rd_n && wr_n)
               nxt_state = ST_GRANT; // [R7]
         ST_RELEASE:
            nxt_state = ST_IDLE;
         default:
            nxt_state = ST_IDLE;
      endcase
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         state_ff <= ST_IDLE;
      else
         state_ff <= nxt_state;
   end

   ////////////////////////////////////////////////////////////////////////
   // Grant falls one edge after the interface stopped driving
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         grant_n_ff <= 1'b1;
      else if (nxt_state == ST_RELEASE || nxt_state == ST_IDLE || nxt_state == ST_WAIT_BUS)
         grant_n_ff <= 1'b1; // [R10]
      else if (state_ff == ST_TRISTATE)
         grant_n_ff <= 1'b0; // [R10] [R13]
   end

   // Memory interface and address clock share one enable
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         mem_oe_ff <= 1'b1;
      else if (!suspend_bus_tristate_n_n)
         mem_oe_ff <= 1'b0; // [R11] [R15]
      else if (nxt_state == ST_TRISTATE)
         mem_oe_ff <= 1'b0; // [R10] [R12] [R13]
      else if ((state_ff == ST_IDLE || state_ff == ST_WAIT_BUS) && grant_n_ff)
         mem_oe_ff <= 1'b1; // [R10] [R15]
   end

   // Grant pin floats only when neither the interface nor a grant drives it
   // Mirrors the next values of both enables so the pin comes from one flop
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         grant_oe_ff <= 1'b1;
      else if (state_ff == ST_TRISTATE)
         grant_oe_ff <= 1'b1; // [R10]
      else if (!grant_n_ff && nxt_state != ST_RELEASE && nxt_state != ST_IDLE && nxt_state != ST_WAIT_BUS)
         grant_oe_ff <= 1'b1; // [R10]
      else if (!suspend_bus_tristate_n_n || nxt_state == ST_TRISTATE)
         grant_oe_ff <= 1'b0; // [R12] [R15]
      else if ((state_ff == ST_IDLE || state_ff == ST_WAIT_BUS) && grant_n_ff)
         grant_oe_ff <= 1'b1; // [R13]
      else
         grant_oe_ff <= mem_oe_ff;
   end

   ////////////////////////////////////////////////////////////////////////
   // Ready: low while waiting for grant and during an access
   always_comb
   begin
      nxt_ready = ready_ff;
      if (!host_req && state_ff != ST_ACCESS)
         nxt_ready = 1'b1;
      else if (nxt_state == ST_ACCESS)
         nxt_ready = 1'b0; // [R6]
      else if (state_ff == ST_ACCESS && acc_done_i)
         nxt_ready = 1'b1; // [R6] [R9]
      else if (state_ff == ST_WAIT_BUS || state_ff == ST_TRISTATE || state_ff == ST_IDLE)
         nxt_ready = 1'b0; // [R16]
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ready_ff <= 1'b1;
      else
         ready_ff <= nxt_ready; // [R9]
   end

   // Open drain only drives while pulling low
   // Enable follows the next level, else it would drive high for a cycle
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         ready_oe_ff <= 1'b0;
      else if (ready_open_drain_i)
         ready_oe_ff <= host_req && !nxt_ready; // [R8]
      else
         ready_oe_ff <= host_req; // [R8]
   end

   // Read data driven from completion until strobe rises
   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         data_oe_ff <= 1'b0;
      else if (state_ff == ST_ACCESS && acc_done_i && !acc_write_ff)
         data_oe_ff <= 1'b1; // [R14]
      else if (rd_n)
         data_oe_ff <= 1'b0; // [R14]
   end

   always_ff @(posedge ref_clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         acc_req_ff <= 1'b0;
         acc_write_ff <= 1'b0;
      end
      else
      begin
         acc_req_ff <= state_ff == ST_GRANT && nxt_state == ST_ACCESS; // [R2]
         if (state_ff == ST_GRANT && nxt_state == ST_ACCESS)
            acc_write_ff <= rd_n;
      end
   end

   assign host_bus_grant_n_o = grant_n_ff;
   assign host_bus_grant_oe_o = grant_oe_ff;
   assign host_access_ready_o = ready_ff;
   assign host_access_ready_oe_o = ready_oe_ff;
   assign host_data_oe_o = data_oe_ff;
   assign mem_if_oe_o = mem_oe_ff;
   assign address_clock_out_oe_o = mem_oe_ff;
   assign acc_req_o = acc_req_ff;
   assign acc_write_o = acc_write_ff;
endmodule : hap_host_port

// ===== tb/hap_host_model.sv
`timescale 1ns/1ps
module hap_host_model (
   // Clock and device pins
   input wire logic ref_clk_i,
   input wire logic grant_n_i,
   input wire logic ready_i,
   // Host strobes
   output logic cs_n_o,
   output logic hbr_n_o,
   output logic rd_n_o,
   output logic wr_n_o,
   // Upper address line
   output logic addr_hi_o
);
   // Upper address high from grant on, keeps first access out of shared space
   assign addr_hi_o = !grant_n_i;
   initial {cs_n_o, hbr_n_o, rd_n_o, wr_n_o} = 4'hf;
   ////////////////////////////////////////
   task automatic request(input logic on);
      @(posedge ref_clk_i);
      #5;
      cs_n_o = !on;
      hbr_n_o = !on;
   endtask : request
   // Only called once grant is seen
   task automatic strobe(input logic w, output int n);
      @(posedge ref_clk_i);
      #5;
      if (w)
         wr_n_o = 1'b0;
      else
         rd_n_o = 1'b0;
      for (n = 0; n < 20 && ready_i !== 1'b0; n++)
         @(posedge ref_clk_i);
      for (n = n; n < 80 && ready_i !== 1'b1; n++) // Hold strobe until ready released
         @(posedge ref_clk_i);
      #5;
      rd_n_o = 1'b1;
      wr_n_o = 1'b1;
   endtask : strobe
endmodule : hap_host_model

// ===== tb/hap_host_port_monitor.sv
`timescale 1ns/1ps
module hap_host_port_monitor (
   // Clock and reset
   input wire logic ref_clk_i,
   input wire logic rst_n_i,
   // Watched ports
   input wire logic host_cs_n_i,
   input wire logic host_bus_request_n_i,
   input wire logic suspend_bus_tristate_n_i,
   input wire logic core_bus_busy_i,
   input wire logic acc_done_i,
   input wire logic ready_open_drain_i,
   input wire logic host_bus_grant_n_o,
   input wire logic host_bus_grant_oe_o,
   input wire logic host_access_ready_o,
   input wire logic host_access_ready_oe_o,
   input wire logic host_data_oe_o,
   input wire logic mem_if_oe_o,
   input wire logic address_clock_out_oe_o,
   input wire logic acc_req_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_grant;
      $fell(host_bus_grant_n_o);
   endsequence
   // Margin covers the pin filter latency
   sequence s_holdoff;
      (!host_cs_n_i && !host_bus_request_n_i) [*8] ##0 host_bus_grant_n_o;
   endsequence
   ////////////////////////////////////////
   AST_TRI_FIRST: assert property (s_grant |-> !$past(mem_if_oe_o))
      else $error("grant before tristate");
   AST_TRI_HELD: assert property (!host_bus_grant_n_o |-> !mem_if_oe_o)
      else $error("driving while granted");
   AST_ADDRESS_CLOCK_OUT: assert property (s_grant |-> !$past(address_clock_out_oe_o))
      else $error("clock out driven at grant");
   AST_GRANT_OE: assert property (!host_bus_grant_n_o |-> host_bus_grant_oe_o)
      else $error("grant low but undriven");
   AST_OD_LOW: assert property ($past(ready_open_drain_i) && host_access_ready_oe_o |-> !host_access_ready_o)
      else $error("open drain ready driven high");
   AST_SUSPEND: assert property (!suspend_bus_tristate_n_i [*7] |-> !mem_if_oe_o)
      else $error("suspend ignored");
   AST_BUS_FREE: assert property (s_grant |-> !$past(core_bus_busy_i, 2))
      else $error("grant during bus cycle");
   AST_GRANT_KEPT: assert property ($rose(host_bus_grant_n_o) |-> $past(host_bus_request_n_i, 3))
      else $error("grant dropped early");
   AST_ACC_GRANTED: assert property (acc_req_o |-> !host_bus_grant_n_o ##1 !acc_req_o)
      else $error("access without grant");
   AST_READY_LOW: assert property ($rose(acc_req_o) |-> !host_access_ready_o)
      else $error("ready not pulled low");
   AST_READY_DONE: assert property ($rose(host_access_ready_o) && !host_bus_grant_n_o |-> $past(acc_done_i))
      else $error("ready released early");
   AST_HOLDOFF: assert property (s_holdoff |-> !host_access_ready_o)
      else $error("host not held off");
   AST_DATA_GRANT: assert property (host_data_oe_o |-> !host_bus_grant_n_o)
      else $error("data driven ungranted");
endmodule : hap_host_port_monitor
bind hap_host_port hap_host_port_monitor hap_host_port_monitor_i (.*);

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic ref_clk_i = 1'b0;
   logic rst_n_i = 1'b0;
   logic suspend_bus_tristate_n_i = 1'b1;
   logic ready_open_drain_i = 1'b0;
   logic core_bus_busy_i = 1'b0;
   logic acc_done_i = 1'b0;
   logic host_cs_n_i, host_bus_request_n_i, host_rd_n_i, host_wr_n_i, ready_wire;
   logic host_bus_grant_n_o, host_bus_grant_oe_o, host_access_ready_o, host_access_ready_oe_o;
   logic host_data_oe_o, mem_if_oe_o, address_clock_out_oe_o, acc_req_o, acc_write_o, host_addr_hi;
   int mismatches = 0;
   int n_tests = 0;
   int core_lat = 1;
   // Pull-up on ready, so an undriven pin reads released
   assign ready_wire = host_access_ready_oe_o ? host_access_ready_o : 1'b1;
   always #50 ref_clk_i = ~ref_clk_i;
   hap_host_port hap_host_port_i (.*);
   hap_host_model hap_host_model_i (.ref_clk_i, .grant_n_i(host_bus_grant_n_o), .ready_i(ready_wire),
      .cs_n_o(host_cs_n_i), .hbr_n_o(host_bus_request_n_i), .rd_n_o(host_rd_n_i), .wr_n_o(host_wr_n_i),
      .addr_hi_o(host_addr_hi));
   // Core answers each access after core_lat cycles
   always @(posedge ref_clk_i)
   begin
      #5;
      if (acc_req_o === 1'b1)
      begin
         #(100 * (core_lat - 1)) acc_done_i = 1'b1;
         #100 acc_done_i = 1'b0;
      end
   end
   ////////////////////////////////////////
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic wait_for(ref logic s, input logic v);
      for (int k = 0; k < 40 && s !== v; k++)
         @(posedge ref_clk_i);
      #5;
      chk({7'h0, s}, {7'h0, v});
   endtask : wait_for
   task automatic t_grant;
      core_bus_busy_i = 1'b1;
      hap_host_model_i.request(1'b1);
      repeat (20) @(posedge ref_clk_i);
      #5;
      chk({6'h0, host_bus_grant_n_o, ready_wire}, 8'h02);
      core_bus_busy_i = 1'b0;
      wait_for(host_bus_grant_n_o, 1'b0);
      chk({4'h0, host_addr_hi, mem_if_oe_o, address_clock_out_oe_o, host_bus_grant_oe_o}, 8'h09);
   endtask : t_grant
   task automatic t_xfer(input logic w, input int lat);
      int n;
      core_lat = lat;
      hap_host_model_i.strobe(w, n);
      @(posedge ref_clk_i);
      #5;
      chk({7'h0, n > lat + 3}, 8'h01);
      chk({6'h0, acc_write_o, host_data_oe_o}, {6'h0, w, !w});
      chk({7'h0, host_access_ready_oe_o}, {7'h0, !ready_open_drain_i});
   endtask : t_xfer
   task automatic t_release;
      hap_host_model_i.request(1'b0);
      wait_for(host_bus_grant_n_o, 1'b1);
      wait_for(mem_if_oe_o, 1'b1);
   endtask : t_release
   task automatic t_suspend_bus_tristate_n;
      suspend_bus_tristate_n_i = 1'b0;
      repeat (8) @(posedge ref_clk_i);
      #5;
      chk({6'h0, mem_if_oe_o, host_bus_grant_oe_o}, 8'h00);
      suspend_bus_tristate_n_i = 1'b1;
      wait_for(mem_if_oe_o, 1'b1);
      chk({7'h0, host_bus_grant_oe_o}, 8'h01);
   endtask : t_suspend_bus_tristate_n
   task automatic summarize;
      $display("Comparisons %0d, mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : summarize
   ////////////////////////////////////////
   initial
   begin
      repeat (6) @(posedge ref_clk_i);
      #5;
      chk({host_bus_grant_oe_o, address_clock_out_oe_o, host_bus_grant_n_o, host_access_ready_o,
         host_access_ready_oe_o, host_data_oe_o, mem_if_oe_o, acc_req_o}, 8'hf2);
      rst_n_i = 1'b1;
      repeat (4) @(posedge ref_clk_i);
      #5;
      t_grant;
      t_xfer(1'b0, 1);
      t_xfer(1'b1, 6);
      t_xfer(1'b0, 6);
      t_release;
      t_suspend_bus_tristate_n;
      ready_open_drain_i = 1'b1;
      t_grant;
      t_xfer(1'b0, 2);
      t_release;
      summarize;
   end
   // Whole run is well under this span
   initial
   begin
      #200us;
      mismatches++;
      summarize;
   end
endmodule : tb
